// [hw/core_ctrl_pkg.sv]
// package: register map, field positions and reset values for the core control bank
package core_ctrl_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] CORE2_CONTROL_A_OFS = 8'h06;
    localparam logic [7:0] CORE2_CONTROL_B_OFS = 8'h07;
    localparam logic [7:0] CORE3_CONTROL_A_OFS = 8'h08;
    localparam logic [7:0] CORE3_CONTROL_B_OFS = 8'h09;
    // control a field positions
    localparam int ON_BIT = 7;
    localparam int GATING_BIT = 6;
    localparam int CHOICE_BIT = 5;
    localparam int LEVEL_BIT = 4;
    localparam int DISCHARGE_BIT = 3;
    localparam int FPWM_BIT = 1;
    // control b field positions
    localparam int LIMIT_LSB = 3;
    localparam int RAMP_LSB = 0;
    localparam int FIELD_W = 3;
    // reset values: on, gating, first pin, enable mode, discharge on, auto mode
    localparam logic [7:0] CONTROL_A_RESET = 8'hc8;
    localparam logic [2:0] CORE2_LIMIT_RESET = 3'h4;
    localparam logic [2:0] CORE3_LIMIT_RESET = 3'h6;
    localparam logic [2:0] RAMP_RESET = 3'h2;
    localparam logic [2:0] LIMIT_MIN_CODE = 3'h2;
    localparam int SYNC_STAGES = 2;
endpackage

// [hw/core_cfg_if.sv]
// interface: raw control a register of one core passed to the enable logic, with its run and roof results
`timescale 1ns/10ps
`default_nettype none
interface core_cfg_if;
    logic [7:0] control_a;
    logic run;
    logic roof;
    modport src(output control_a, input run, roof);
    modport dst(input control_a, output run, roof);
endinterface
`default_nettype wire

// [hw/core_enable_logic.sv]
// module: effective enable and roof/floor state of one core from settings and pins
`timescale 1ns/10ps
`default_nettype none
module core_enable_logic (
    // settings and results
    core_cfg_if.dst cfg,
    // synchronised pins
    input wire logic pin_a_sync,
    input wire logic pin_b_sync
);
    import core_ctrl_pkg::*;
    logic pin;
    always_comb begin
        pin = cfg.control_a[CHOICE_BIT] ? pin_b_sync : pin_a_sync;
        cfg.run = cfg.control_a[ON_BIT];
        cfg.roof = 1'b1;
        if (cfg.control_a[GATING_BIT]) begin
            if (cfg.control_a[LEVEL_BIT]) begin
                cfg.roof = pin;
            end else begin
                cfg.run = cfg.control_a[ON_BIT] & pin;
            end
        end
    end
endmodule
`default_nettype wire

// [hw/core_ctrl_regs.sv]
// top: control register bank for the third and fourth step-down cores
// What this block does
// - on bit seven enables the core
// - pin gating ANDs enable with selected pin
// - bit five chooses first or second pin
// - bit four: pin enables or picks roof/floor
// - discharge bit connects resistor when off
// - bit one forces continuous pulse-width mode
// - bits five to three set current limit
// - limit changes apply while core runs
// - bits two to zero set ramp rate
// - fourth core limit resets 0x6, ramp 0x2
// - floor state selects floor voltage setting
`timescale 1ns/10ps
`default_nettype none
module core_ctrl_regs (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port from the serial interface
    input wire logic wr_en,
    input wire logic [core_ctrl_pkg::ADDR_W-1:0] addr,
    input wire logic [core_ctrl_pkg::DATA_W-1:0] wr_data,
    output logic [core_ctrl_pkg::DATA_W-1:0] rd_data,
    // enable pins
    input wire logic enable_pin_a,
    input wire logic enable_pin_b,
    // core 2 controls
    output logic core2_run,
    output logic core2_use_floor,
    output logic core2_discharge,
    output logic core2_forced_pulse_width,
    output logic [2:0] core2_current_limit,
    output logic [2:0] core2_ramp_rate,
    // core 3 controls
    output logic core3_run,
    output logic core3_use_floor,
    output logic core3_discharge,
    output logic core3_forced_pulse_width,
    output logic [2:0] core3_current_limit,
    output logic [2:0] core3_ramp_rate
);
    import core_ctrl_pkg::*;

    // the ports and the byte-wide read function are built for eight-bit registers
    if (ADDR_W != 8 || DATA_W != 8) begin
        $error("register bank needs eight-bit address and data");
    end
    // one stage alone would hand a metastable pin straight to the enable logic
    if (SYNC_STAGES < 2) begin
        $error("pin synchroniser needs at least two stages");
    end
    // both three-bit fields must fit side by side inside control b
    if (LIMIT_LSB + FIELD_W > 8 || RAMP_LSB + FIELD_W > LIMIT_LSB) begin
        $error("control b fields overlap or overflow the register");
    end
    // codes below the lowest defined limit step must not be the value after reset
    if (CORE2_LIMIT_RESET < LIMIT_MIN_CODE || CORE3_LIMIT_RESET < LIMIT_MIN_CODE) begin
        $error("current limit reset code below the lowest defined step");
    end
    // the four control registers need four distinct offsets; only four of the six pairs are compared (2A-3B and 2B-3A are not)
    if (CORE2_CONTROL_A_OFS == CORE2_CONTROL_B_OFS || CORE2_CONTROL_A_OFS == CORE3_CONTROL_A_OFS
        || CORE2_CONTROL_B_OFS == CORE3_CONTROL_B_OFS
        || CORE3_CONTROL_A_OFS == CORE3_CONTROL_B_OFS) begin
        $error("control register offsets collide");
    end

    logic [7:0] c2a_ff, c2b_ff, c3a_ff, c3b_ff;
    logic [7:0] nxt_c2a, nxt_c2b, nxt_c3a, nxt_c3b;
    logic [7:0] rd_data_ff, nxt_rd_data;
    logic [SYNC_STAGES-1:0] pin_a_ff, pin_b_ff, nxt_pin_a, nxt_pin_b;
    logic [3:0] out2_ff, out3_ff, nxt_out2, nxt_out3;
    logic [2:0] lim2_ff, lim3_ff, ramp2_ff, ramp3_ff;
    logic [2:0] nxt_lim2, nxt_lim3, nxt_ramp2, nxt_ramp3;

    // control b after reset: reserved bits clear, per-core limit, common ramp
    function automatic logic [7:0] control_b_reset(input logic [2:0] limit);
        control_b_reset = {2'b00, limit, RAMP_RESET};
    endfunction

    // {run, floor, discharge, forced}: floor only while running, discharge only while off
    function automatic logic [3:0] core_outputs(input logic run, input logic roof,
        input logic [7:0] control_a);
        logic at_floor;
        logic discharge;
        at_floor = run & ~roof;
        discharge = ~run & control_a[DISCHARGE_BIT];
        core_outputs = {run, at_floor, discharge, control_a[FPWM_BIT]};
    endfunction

    // one three-bit field of a control b register
    function automatic logic [2:0] field_of(input logic [7:0] control_b, input int lsb);
        field_of = control_b[lsb +: FIELD_W];
    endfunction

    // unmapped offsets read as zero so a stray read cannot alias a register
    function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] r2a,
        input logic [7:0] r2b, input logic [7:0] r3a, input logic [7:0] r3b);
        case (a)
            CORE2_CONTROL_A_OFS: reg_read = r2a;
            CORE2_CONTROL_B_OFS: reg_read = r2b;
            CORE3_CONTROL_A_OFS: reg_read = r3a;
            CORE3_CONTROL_B_OFS: reg_read = r3b;
            default: reg_read = 8'h00;
        endcase
    endfunction

    // all eight bits stored so reserved bits read back what was written
    // read data takes the post-write value, so a read in the write cycle sees new data
    always_comb begin
        nxt_c2a = c2a_ff;
        nxt_c2b = c2b_ff;
        nxt_c3a = c3a_ff;
        nxt_c3b = c3b_ff;
        if (wr_en) begin
            case (addr)
                CORE2_CONTROL_A_OFS: nxt_c2a = wr_data;
                CORE2_CONTROL_B_OFS: nxt_c2b = wr_data;
                CORE3_CONTROL_A_OFS: nxt_c3a = wr_data;
                CORE3_CONTROL_B_OFS: nxt_c3b = wr_data;
                default: ;
            endcase
        end
        nxt_rd_data = reg_read(addr, nxt_c2a, nxt_c2b, nxt_c3a, nxt_c3b);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            c2a_ff <= CONTROL_A_RESET;
            c2b_ff <= control_b_reset(CORE2_LIMIT_RESET);
            c3a_ff <= CONTROL_A_RESET;
            c3b_ff <= control_b_reset(CORE3_LIMIT_RESET);
            rd_data_ff <= 8'h00;
        end else begin
            c2a_ff <= nxt_c2a;
            c2b_ff <= nxt_c2b;
            c3a_ff <= nxt_c3a;
            c3b_ff <= nxt_c3b;
            rd_data_ff <= nxt_rd_data;
        end
    end

    // two-stage synchronisers; only the last stage feeds logic
    always_comb begin
        nxt_pin_a = {pin_a_ff[SYNC_STAGES-2:0], enable_pin_a};
        nxt_pin_b = {pin_b_ff[SYNC_STAGES-2:0], enable_pin_b};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_a_ff <= '0;
            pin_b_ff <= '0;
        end else begin
            pin_a_ff <= nxt_pin_a;
            pin_b_ff <= nxt_pin_b;
        end
    end

    // each core has its own settings bundle; the synchronised pins are shared
    core_cfg_if cfg2();
    core_cfg_if cfg3();
    assign cfg2.control_a = c2a_ff;
    assign cfg3.control_a = c3a_ff;

    core_enable_logic u_core2 (
        .cfg(cfg2),
        .pin_a_sync(pin_a_ff[SYNC_STAGES-1]),
        .pin_b_sync(pin_b_ff[SYNC_STAGES-1])
    );
    core_enable_logic u_core3 (
        .cfg(cfg3),
        .pin_a_sync(pin_a_ff[SYNC_STAGES-1]),
        .pin_b_sync(pin_b_ff[SYNC_STAGES-1])
    );

    // outputs lag their registers by a cycle so every pin leaves a flip-flop
    always_comb begin
        nxt_out2 = core_outputs(cfg2.run, cfg2.roof, c2a_ff);
        nxt_out3 = core_outputs(cfg3.run, cfg3.roof, c3a_ff);
        // limit codes pass through at any time, running core or not
        nxt_lim2 = field_of(c2b_ff, LIMIT_LSB);
        nxt_lim3 = field_of(c3b_ff, LIMIT_LSB);
        nxt_ramp2 = field_of(c2b_ff, RAMP_LSB);
        nxt_ramp3 = field_of(c3b_ff, RAMP_LSB);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out2_ff <= 4'h0;
            out3_ff <= 4'h0;
            lim2_ff <= CORE2_LIMIT_RESET;
            lim3_ff <= CORE3_LIMIT_RESET;
            ramp2_ff <= RAMP_RESET;
            ramp3_ff <= RAMP_RESET;
        end else begin
            out2_ff <= nxt_out2;
            out3_ff <= nxt_out3;
            lim2_ff <= nxt_lim2;
            lim3_ff <= nxt_lim3;
            ramp2_ff <= nxt_ramp2;
            ramp3_ff <= nxt_ramp3;
        end
    end

    // every output pin is a flip-flop bit, never a gate
    assign rd_data = rd_data_ff;
    assign core2_run = out2_ff[3];
    assign core2_use_floor = out2_ff[2];
    assign core2_discharge = out2_ff[1];
    assign core2_forced_pulse_width = out2_ff[0];
    assign core2_current_limit = lim2_ff;
    assign core2_ramp_rate = ramp2_ff;
    assign core3_run = out3_ff[3];
    assign core3_use_floor = out3_ff[2];
    assign core3_discharge = out3_ff[1];
    assign core3_forced_pulse_width = out3_ff[0];
    assign core3_current_limit = lim3_ff;
    assign core3_ramp_rate = ramp3_ff;
endmodule
`default_nettype wire

// [verification/core_host_model.sv]
// host model: drives the register port and the two enable pins
`timescale 1ns/10ps
`default_nettype none
module core_host_model (
    // clock and read data
    input wire logic clk,
    input wire logic [7:0] rd_data,
    // register port and pins
    output logic wr_en,
    output logic [7:0] addr,
    output logic [7:0] wr_data,
    output logic pin_a,
    output logic pin_b
);
    initial {wr_en, addr, wr_data, pin_a, pin_b} = '0;
    // idles on an unmapped address with inverted data so nothing stale looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk) {wr_en, addr, wr_data} = {1'b1, a, d};
        @(negedge clk) {wr_en, addr, wr_data} = {1'b0, 8'hff, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk) addr = a;
        @(negedge clk) d = rd_data;
    endtask
    task automatic pins(input logic a, input logic b);
        @(negedge clk) {pin_a, pin_b} = {a, b};
    endtask
endmodule
`default_nettype wire

// [verification/core_ctrl_regs_assertions.sv]
// checker for the core control register bank ports
`timescale 1ns/10ps
`default_nettype none
module core_ctrl_regs_assertions (
    // clock, reset and register port
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    // core outputs
    input wire logic core2_run,
    input wire logic core2_use_floor,
    input wire logic core2_discharge,
    input wire logic [2:0] core2_ramp_rate,
    input wire logic core3_run,
    input wire logic core3_discharge,
    input wire logic core3_forced_pulse_width,
    input wire logic [2:0] core3_current_limit
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // a write not followed by another, so its value lands undisturbed
    sequence lone_wr(logic [7:0] a);
        wr_en && addr == a ##1 !wr_en;
    endsequence
    limit_apply_a: assert property (lone_wr(8'h09) |=> core3_current_limit == $past(wr_data[5:3], 2))
        else $error("current limit not applied");
    ramp_apply_a: assert property (lone_wr(8'h07) |=> core2_ramp_rate == $past(wr_data[2:0], 2))
        else $error("ramp rate not applied");
    pwm_apply_a: assert property (lone_wr(8'h08) |=> core3_forced_pulse_width == $past(wr_data[1], 2))
        else $error("forced mode not applied");
    core_off_a: assert property (wr_en && addr == 8'h06 && !wr_data[7] ##1 !wr_en |=> !core2_run)
        else $error("core runs with on bit clear");
    write_read_a: assert property (wr_en && addr == 8'h06 |=> rd_data == $past(wr_data))
        else $error("read back differs from write");
    unmapped_zero_a: assert property (!(addr inside {[8'h06:8'h09]}) |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    floor_run_a: assert property (core2_use_floor |-> core2_run)
        else $error("floor while off");
    discharge_off_a: assert property (core3_discharge |-> !core3_run)
        else $error("discharge while running");
    // a lone write to core 2 control a with neither the on bit nor pin gating set
    sequence off_wr;
        wr_en && addr == 8'h06 && wr_data[7:6] == 2'b00 ##1 !wr_en;
    endsequence
    discharge_pick_a: assert property (off_wr |=> core2_discharge == $past(wr_data[3], 2))
        else $error("discharge does not follow its bit while off");
endmodule
bind core_ctrl_regs core_ctrl_regs_assertions chk_i (.*);
`default_nettype wire

// [verification/tb_core_ctrl_regs.sv]
// testbench for the core control register bank
`timescale 1ns/10ps
`default_nettype none
module tb_core_ctrl_regs;
    logic clk = 0, rst_n = 0, wr_en, enable_pin_a, enable_pin_b;
    logic [7:0] addr, wr_data, rd_data, d;
    logic core2_run, core2_use_floor, core2_discharge, core2_forced_pulse_width;
    logic core3_run, core3_use_floor, core3_discharge, core3_forced_pulse_width;
    logic [2:0] core2_current_limit, core2_ramp_rate, core3_current_limit, core3_ramp_rate;
    wire logic [7:0] st = {core2_run, core2_use_floor, core2_discharge, core2_forced_pulse_width,
        core3_run, core3_use_floor, core3_discharge, core3_forced_pulse_width};
    int n_fail = 0, n_compared = 0, cycles = 0;
    initial forever #5 clk = ~clk;
    core_host_model host (.clk(clk), .rd_data(rd_data), .wr_en(wr_en), .addr(addr),
        .wr_data(wr_data), .pin_a(enable_pin_a), .pin_b(enable_pin_b));
    core_ctrl_regs DUT (.*);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, d);
        chk(d, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wrap_up;
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_fail++;
            wrap_up();
        end
    end
    initial begin
        cyc(4);
        rst_n = 1;
        cyc(1);
        chk(st, 8'h22);
        chk({2'b00, core2_current_limit, core2_ramp_rate}, 8'h22);
        chk({2'b00, core3_current_limit, core3_ramp_rate}, 8'h32);
        rchk(8'h06, 8'hc8);
        rchk(8'h07, 8'h22);
        rchk(8'h08, 8'hc8);
        rchk(8'h09, 8'h32);
        rchk(8'h05, 8'h00);
        rchk(8'h0a, 8'h00);
        $display("reset test done");
        host.pins(1'b1, 1'b0);
        cyc(2);
        chk(st, 8'h22);
        cyc(1);
        chk(st, 8'h88);
        host.wr(8'h08, 8'he8);
        cyc(1);
        chk(st, 8'h82);
        host.pins(1'b0, 1'b1);
        cyc(3);
        chk(st, 8'h28);
        host.wr(8'h06, 8'hd8);
        cyc(1);
        chk(st, 8'hc8);
        host.pins(1'b1, 1'b1);
        cyc(3);
        chk(st, 8'h88);
        $display("pin test done");
        host.wr(8'h09, 8'hfa);
        cyc(1);
        chk({2'b00, core3_current_limit, core3_ramp_rate}, 8'h3a);
        rchk(8'h09, 8'hfa);
        host.wr(8'h07, 8'h07);
        cyc(1);
        chk({2'b00, core2_current_limit, core2_ramp_rate}, 8'h07);
        host.pins(1'b0, 1'b0);
        host.wr(8'h06, 8'h82);
        cyc(1);
        chk(st, 8'h92);
        host.wr(8'h06, 8'h08);
        cyc(1);
        chk(st, 8'h22);
        host.wr(8'h06, 8'h00);
        cyc(1);
        chk(st, 8'h02);
        $display("field test done");
        rst_n = 0;
        cyc(2);
        rst_n = 1;
        cyc(1);
        chk(st, 8'h22);
        rchk(8'h06, 8'hc8);
        rchk(8'h09, 8'h32);
        $display("mid-run reset test done");
        wrap_up();
    end
endmodule
`default_nettype wire
